/* src/encoder_status_alarm_regs.v */
// read-only status, alarm and identity register bank of the encoder
// answers one 16-bit word per read request, one cycle after it is taken
// assumes raw position and condition inputs arrive from the same clock
// domain; read requests come one at a time from the protocol engine,
// which splits multi-register reads into single words, high word first
`timescale 1ns/1ps
`include "encoder_status_map.vh"
module encoder_status_alarm_regs #(
  parameter SPEED_CYC = `SPEED_PERIOD_CYC,
  // arbitrary version values
  parameter [15:0] FW_MAJOR = 16'h0001,
  parameter [15:0] FW_MINOR = 16'h0000,
  parameter [15:0] BOARD_MAJOR = 16'h0001,
  parameter [15:0] BOARD_MINOR = 16'h0000
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // position source and configuration
  input wire [31:0] raw_position,
  input wire [31:0] preset_value,
  input wire [31:0] counts_per_rev,
  input wire [31:0] total_resolution,
  input wire scaling_on,
  input wire count_ccw,
  input wire speed_rpm,
  // command word bits
  input wire cmd_preset,
  input wire cmd_restore,
  input wire cmd_save,
  // parameter validity and storage health
  input wire cpr_invalid,
  input wire total_invalid,
  input wire preset_invalid,
  input wire flash_fault,
  // read request from protocol engine
  input wire rd_req,
  input wire [7:0] rd_func,
  input wire [15:0] rd_addr,
  // read answer
  output reg rd_ack_r,
  output reg rd_err_r,
  output reg [15:0] rd_data_r
);

  // ==========================================
  // command edges
  // each command acts once per rising edge; holding the bit high does nothing more
  wire [2:0] cmd_lvl;
  wire [2:0] cmd_rise;
  reg [2:0] cmd_d_r;
  wire preset_rise;
  wire restore_rise;
  wire save_rise;
  assign cmd_lvl = {cmd_save, cmd_restore, cmd_preset};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_edge
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
          cmd_d_r[g] <= 1'b0;
        else
          cmd_d_r[g] <= cmd_lvl[g];
      end
      assign cmd_rise[g] = cmd_lvl[g] & ~cmd_d_r[g];
    end
  endgenerate
  assign preset_rise = cmd_rise[0];
  assign restore_rise = cmd_rise[1];
  assign save_rise = cmd_rise[2];

  // ==========================================
  // offset capture
  reg [31:0] offset_r;
  reg [31:0] offset_nxt;
  // restore outranks a capture in the same cycle: defaults must come back
  // whole, and the client can repeat the preset afterwards
  always @* begin
    offset_nxt = offset_r;
    if (restore_rise)
      offset_nxt = `OFFSET_RESET;
    else if (preset_rise)
      offset_nxt = raw_position;
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      offset_r <= `OFFSET_RESET;
    else
      offset_r <= offset_nxt;
  end

  // ==========================================
  // transmitted position
  wire [31:0] dir_pos;
  wire [31:0] dir_off;
  wire [31:0] shifted;
  wire [31:0] pos_nxt;
  wire [31:0] pos_out;
  reg [31:0] pos_r;

  // the offset follows the count direction so a preset stays put when read
  assign dir_pos = count_ccw ? (32'h00000000 - raw_position) : raw_position;
  assign dir_off = count_ccw ? (32'h00000000 - offset_r) : offset_r;
  assign shifted = dir_pos - dir_off + preset_value;
  // physical mode ignores custom limits; scaled mode wraps at total resolution
  assign pos_nxt = (scaling_on && total_resolution != 32'h00000000)
    ? shifted % total_resolution : shifted;
  // the divider makes a long path; a flop after it costs one cycle of lag
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      pos_r <= 32'h00000000;
    else
      pos_r <= pos_nxt;
  end
  assign pos_out = pos_r;

  // ==========================================
  // speed
  // speed works on the transmitted position, so it follows preset and direction
  wire [31:0] speed_val;
  speed_sampler #(
    .PERIOD_CYC(SPEED_CYC)
  ) u_speed (
    .clk(clk),
    .arst_n(arst_n),
    .pos(pos_out),
    .rpm_mode(speed_rpm),
    .counts_per_rev(counts_per_rev),
    .speed_r(speed_val)
  );

  // ==========================================
  // parameter validity and alarms
  reg offset_bad_r;
  reg offset_bad_nxt;
  reg flash_alarm_r;
  reg flash_alarm_nxt;
  reg [31:0] alarm_r;
  reg [31:0] alarm_nxt;
  reg [31:0] state_r;
  reg [31:0] state_nxt;
  reg [3:0] bad_params_r;
  wire [3:0] bad_params;
  wire machine_alarm;
  wire any_alarm;
  // offset health follows the last save; a restore alone leaves it as it was
  always @* begin
    offset_bad_nxt = offset_bad_r;
    if (save_rise)
      offset_bad_nxt = (offset_r[31] != 1'b0) || preset_invalid;
  end
  // sticky: no command path reaches this flag, only a reset clears it
  always @* begin
    flash_alarm_nxt = flash_alarm_r;
    if (flash_fault)
      flash_alarm_nxt = 1'b1;
  end
  assign bad_params = {offset_bad_r, preset_invalid, total_invalid, cpr_invalid};
  // held while any parameter is bad, drops once all are fixed
  assign machine_alarm = |bad_params;
  assign any_alarm = machine_alarm | flash_alarm_r;

  // the words are built field by field and registered, so a reply never
  // mixes old and new conditions; one cycle of lag is far below any poll rate
  always @* begin
    alarm_nxt = 32'h00000000;
    alarm_nxt[`ALM_MACHINE_BIT] = machine_alarm;
    alarm_nxt[`ALM_SETTING_BIT] = 1'b0;
    alarm_nxt[`ALM_FLASH_BIT] = flash_alarm_r;
    state_nxt = 32'h00000000;
    state_nxt[`ST_SCALING_BIT] = scaling_on;
    state_nxt[`ST_DIRECTION_BIT] = count_ccw;
    state_nxt[`ST_ALARM_BIT] = any_alarm;
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_bad_r <= 1'b0;
      flash_alarm_r <= 1'b0;
      alarm_r <= 32'h00000000;
      state_r <= 32'h00000000;
      bad_params_r <= 4'h0;
    end else begin
      offset_bad_r <= offset_bad_nxt;
      flash_alarm_r <= flash_alarm_nxt;
      alarm_r <= alarm_nxt;
      state_r <= state_nxt;
      bad_params_r <= bad_params;
    end
  end

  // ==========================================
  // read decode
  function [31:0] pick_input;
    input [15:0] base;
    input [31:0] pos;
    input [31:0] spd;
    input [31:0] st;
    input [31:0] alm;
    input [3:0] bp;
    input [31:0] off;
    begin
      case (base)
        `IR_POSITION: pick_input = pos;
        `IR_SPEED: pick_input = spd;
        `IR_STATE: pick_input = st;
        `IR_WARN_CAP: pick_input = 32'h00000000;
        `IR_ALARMS: pick_input = alm;
        `IR_WARN_ACT: pick_input = 32'h00000000;
        `IR_BADPARAM: pick_input = {28'h0000000, bp};
        `IR_OFFSET: pick_input = off;
        `IR_FW_REV: pick_input = {FW_MAJOR, FW_MINOR};
        `IR_BOARD_REV: pick_input = {BOARD_MAJOR, BOARD_MINOR};
        default: pick_input = 32'h00000000;
      endcase
    end
  endfunction

  function valid_input;
    input [15:0] base;
    begin
      case (base)
        `IR_POSITION,
        `IR_SPEED,
        `IR_STATE,
        `IR_WARN_CAP,
        `IR_ALARMS,
        `IR_WARN_ACT,
        `IR_BADPARAM,
        `IR_OFFSET,
        `IR_FW_REV,
        `IR_BOARD_REV: valid_input = 1'b1;
        default: valid_input = 1'b0;
      endcase
    end
  endfunction

  // ==========================================
  // holding mirrors
  localparam [15:0] NO_REG = 16'hFFFF;
  // only position, speed and status have holding twins
  function [15:0] mirror_base;
    input [15:0] base;
    begin
      case (base)
        `HR_POSITION: mirror_base = `IR_POSITION;
        `HR_SPEED: mirror_base = `IR_SPEED;
        `HR_STATE: mirror_base = `IR_STATE;
        default: mirror_base = NO_REG;
      endcase
    end
  endfunction

  // ==========================================
  // request decode
  wire [15:0] base_addr;
  wire lo_word;
  wire is_input;
  wire is_holding;
  wire [15:0] reg_base;
  wire [31:0] word32;
  wire hit;
  wire moving;
  reg [15:0] data_nxt;
  reg err_nxt;

  assign base_addr = {rd_addr[15:1], 1'b0};
  assign lo_word = rd_addr[0];
  assign is_input = (rd_func == `FC_READ_INPUT);
  assign is_holding = (rd_func == `FC_READ_HOLDING);
  assign reg_base = is_input ? base_addr : mirror_base(base_addr);
  assign word32 = pick_input(reg_base, pos_out, speed_val, state_r, alarm_r,
    bad_params_r, offset_r);
  // anything else, writes included, is refused: these registers are read-only
  assign hit = is_input ? valid_input(base_addr) :
    is_holding ? (reg_base != NO_REG) : 1'b0;
  // position and speed can change between the two word reads of a pair
  assign moving = (reg_base == `IR_POSITION) || (reg_base == `IR_SPEED);

  // ==========================================
  // pair coherence
  // a high-word read of a moving value keeps its low word; the next read,
  // if it is the low word of that value, gets the kept half so the pair
  // cannot tear. any other read drops it, so lone low-word reads stay live
  reg [15:0] lo_keep_r;
  reg [15:0] lo_keep_nxt;
  reg [15:0] keep_base_r;
  reg [15:0] keep_base_nxt;
  reg keep_ok_r;
  reg keep_ok_nxt;
  always @* begin
    lo_keep_nxt = lo_keep_r;
    keep_base_nxt = keep_base_r;
    keep_ok_nxt = keep_ok_r;
    if (rd_req) begin
      keep_ok_nxt = 1'b0;
      if (hit && moving && !lo_word) begin
        lo_keep_nxt = word32[15:0];
        keep_base_nxt = reg_base;
        keep_ok_nxt = 1'b1;
      end
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_keep_r <= 16'h0000;
      keep_base_r <= NO_REG;
      keep_ok_r <= 1'b0;
    end else begin
      lo_keep_r <= lo_keep_nxt;
      keep_base_r <= keep_base_nxt;
      keep_ok_r <= keep_ok_nxt;
    end
  end

  // ==========================================
  // read answer
  // refused requests answer with zero data and the error flag
  always @* begin
    data_nxt = 16'h0000;
    err_nxt = 1'b0;
    if (!hit)
      err_nxt = 1'b1;
    else if (!lo_word)
      data_nxt = word32[31:16];
    else if (keep_ok_r && keep_base_r == reg_base)
      data_nxt = lo_keep_r;
    else
      data_nxt = word32[15:0];
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ack_r <= 1'b0;
      rd_err_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      rd_ack_r <= rd_req;
      rd_err_r <= rd_req & err_nxt;
      if (rd_req)
        rd_data_r <= data_nxt;
    end
  end
endmodule

/* src/encoder_status_map.vh */
// register map, field positions and timing counts of the encoder status bank
// assumes a 250 MHz core clock; register offsets are 16-bit word indices
// Functional notes
// - supported-warnings register pair always reads zero.
// - active-warnings register pair always reads zero.
// - alarm bits 12 machine data, 13 setting data, 14 flash fault; others zero.
// - an alarm bit stays set until its cause clears and position is valid; here flash fault never clears, machine data clears with no position check.
// - setting-data-invalid alarm bit is never raised.
// - flash fault alarm sets on storage fault and nothing clears it.
// - machine-data alarm set while any parameter invalid; clears when all fixed.
// - invalid list bits 0 counts, 1 total res, 2 preset, 3 offset.
// - offset error set when invalid offset saved, cleared when valid saved.
// - preset command rising edge captures current position into signed offset.
// - transmitted position uses captured offset together with preset value.
// - offset resets to zero, and returns to zero only on restore defaults.
// - firmware revision holds major in bits 31..16, minor in 15..0.
// - board revision holds major in upper 16 bits, minor in lower.
// - input registers are read-only, read with function code 04.
// - position read is 32-bit count sampled at request, scaled.
// - position also readable as holding registers 94..95 with code 03.
// - signed speed value recomputed every 100 ms.
// - speed in steps per second or rpm by speed format setting.
// - speed also readable as holding registers 96..97.
// - status low byte mirrors operating bits, byte 1 alarms, rest zero.
// - status bit 0 is one when custom scaling is active.
// - status bit 1 mirrors count direction, one for counter-clockwise.
// - status bit 8 is one whenever any alarm is active.
`ifndef ENCODER_STATUS_MAP_VH
`define ENCODER_STATUS_MAP_VH
`define FC_READ_HOLDING 8'h03
`define FC_READ_INPUT 8'h04
`define IR_POSITION 16'h0000
`define IR_SPEED 16'h0002
`define IR_STATE 16'h0004
`define IR_WARN_CAP 16'h0076
`define IR_ALARMS 16'h0078
`define IR_WARN_ACT 16'h007A
`define IR_BADPARAM 16'h007C
`define IR_OFFSET 16'h007E
`define IR_FW_REV 16'h0080
`define IR_BOARD_REV 16'h0082
`define HR_POSITION 16'h005E
`define HR_SPEED 16'h0060
`define HR_STATE 16'h0062
`define ALM_MACHINE_BIT 12
`define ALM_SETTING_BIT 13
`define ALM_FLASH_BIT 14
`define ST_SCALING_BIT 0
`define ST_DIRECTION_BIT 1
`define ST_ALARM_BIT 8
`define BP_CPR_BIT 0
`define BP_TOTAL_BIT 1
`define BP_PRESET_BIT 2
`define BP_OFFSET_BIT 3
`define OFFSET_RESET 32'h00000000
`define SPEED_PERIOD_MS 100
`define CLK_MHZ 250
`define SPEED_PERIOD_CYC (`SPEED_PERIOD_MS * 1000 * `CLK_MHZ)
`endif

/* src/speed_sampler.v */
// periodic speed sampler: position delta over a fixed window
// assumes position and format are synchronous to clk
`timescale 1ns/1ps
`include "encoder_status_map.vh"
module speed_sampler #(
  parameter PERIOD_CYC = `SPEED_PERIOD_CYC
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // position and format
  input wire [31:0] pos,
  input wire rpm_mode,
  input wire [31:0] counts_per_rev,
  // result
  output reg [31:0] speed_r
);
  // ==========================================
  // window timer
  reg [31:0] tick_r;
  reg [31:0] last_pos_r;
  wire [31:0] delta;
  wire [63:0] rpm_prod;
  wire [31:0] rpm_val;
  wire [63:0] rpm_quot;
  wire [31:0] cpr_safe;
  assign delta = pos - last_pos_r;
  // 10 windows per second: steps/s = delta*10; rpm = delta*600/cpr
  assign rpm_prod = $signed(delta) * 64'sd600;
  assign cpr_safe = (counts_per_rev == 32'h00000000) ? 32'h00000001 : counts_per_rev;
  // signed divide so a reverse rotation keeps its sign in rpm
  assign rpm_quot = $signed(rpm_prod) / $signed({32'h00000000, cpr_safe});
  assign rpm_val = rpm_quot[31:0];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= 32'h00000000;
      last_pos_r <= 32'h00000000;
      speed_r <= 32'h00000000;
    end else if (tick_r >= PERIOD_CYC - 1) begin
      tick_r <= 32'h00000000;
      last_pos_r <= pos;
      speed_r <= rpm_mode ? rpm_val : delta * 32'h0000000A;
    end else begin
      tick_r <= tick_r + 32'h00000001;
    end
  end
endmodule

/* tb/encoder_status_monitor.sv */
// assertions on the read port of the status bank
// assumes a bind to encoder_status_alarm_regs, ports only
`timescale 1ns/1ps
module encoder_status_monitor #(
  parameter [15:0] FW_MAJOR = 16'h0001
) (
  // clock, reset, conditions
  input wire clk,
  input wire arst_n,
  input wire scaling_on,
  input wire count_ccw,
  input wire flash_fault,
  // read port
  input wire rd_req,
  input wire [7:0] rd_func,
  input wire [15:0] rd_addr,
  input wire rd_ack_r,
  input wire rd_err_r,
  input wire [15:0] rd_data_r
);
  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire rd_in = rd_req && rd_func == 8'h04;
  // sticky copy; one extra cycle of history lets the alarm land
  reg flash_seen_r;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      flash_seen_r <= 1'b0;
    else if (flash_fault)
      flash_seen_r <= 1'b1;
  end
  a_ack_next: assert property (rd_req |=> rd_ack_r) else $error("no ack");
  a_ack_only: assert property (!rd_req |=> !rd_ack_r) else $error("stray ack");
  a_err_zero: assert property (rd_err_r |-> rd_ack_r && rd_data_r == 16'h0000)
    else $error("bad refusal");
  a_bad_func: assert property (rd_req && rd_func != 8'h03 && rd_func != 8'h04 |=> rd_err_r)
    else $error("func taken");
  a_warn_zero: assert property (rd_in && (rd_addr[15:1] == 15'h003B ||
    rd_addr[15:1] == 15'h003D) |=> rd_data_r == 16'h0000) else $error("warn set");
  a_alarm_unused: assert property (rd_in && rd_addr[15:1] == 15'h003C |=>
    (rd_data_r & ($past(rd_addr[0]) ? 16'hAFFF : 16'hFFFF)) == 16'h0000) else $error("alarm bits");
  a_flash_sticky: assert property (rd_in && rd_addr == 16'h0079 && $past(flash_seen_r) |=>
    rd_data_r[14]) else $error("flash lost");
  a_state_mirror: assert property (rd_in && rd_addr == 16'h0005 && $stable(scaling_on) &&
    $stable(count_ccw) |=> rd_data_r[7:0] == {6'h00, $past(count_ccw), $past(scaling_on)})
    else $error("state bits");
  a_fw_major: assert property (rd_in && rd_addr == 16'h0080 |=> rd_data_r == FW_MAJOR)
    else $error("fw major");
endmodule
bind encoder_status_alarm_regs encoder_status_monitor #(.FW_MAJOR(FW_MAJOR)) i_mon (.clk,
  .arst_n, .scaling_on, .count_ccw, .flash_fault, .rd_req, .rd_func, .rd_addr, .rd_ack_r,
  .rd_err_r, .rd_data_r);

/* tb/modbus_client.sv */
// network client model issuing word reads
// assumes one read in flight at a time
`timescale 1ns/1ps
module modbus_client (
  // clock
  input wire clk,
  // read port
  output reg rd_req,
  output reg [7:0] rd_func,
  output reg [15:0] rd_addr,
  input wire rd_ack_r,
  input wire rd_err_r,
  input wire [15:0] rd_data_r
);
  // ==========================================
  // reads
  initial begin
    rd_req = 1'b0;
    rd_func = 8'h00;
    rd_addr = 16'h0000;
  end
  // idle lines are inverted so nothing leans on stale values
  task rd_word(input [7:0] f, input [15:0] a, output [15:0] d, output e);
    integer n;
    begin
      @(posedge clk);
      rd_req <= 1'b1;
      rd_func <= f;
      rd_addr <= a;
      @(posedge clk);
      rd_req <= 1'b0;
      rd_func <= ~f;
      rd_addr <= ~a;
      n = 0;
      while (rd_ack_r !== 1'b1 && n < 8) begin
        @(posedge clk);
        n = n + 1;
      end
      d = rd_data_r;
      e = (n < 8) ? rd_err_r : 1'bx;
    end
  endtask
  task rd_pair(input [7:0] f, input [15:0] a, output [31:0] v, output e);
    reg e1;
    begin
      rd_word(f, a, v[31:16], e);
      rd_word(f, a + 16'h1, v[15:0], e1);
      e = e | e1;
    end
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench of the encoder status bank
// assumes the client model drives the read port
`timescale 1ns/1ps
module tb;
  reg clk, arst_n, scaling_on, count_ccw, speed_rpm, cmd_preset, cmd_restore, cmd_save;
  reg cpr_invalid, total_invalid, preset_invalid, flash_fault, ramp, e;
  reg [31:0] raw_position, preset_value, counts_per_rev, total_resolution, v;
  reg [15:0] w;
  wire rd_req, rd_ack_r, rd_err_r;
  wire [7:0] rd_func;
  wire [15:0] rd_addr, rd_data_r;
  integer n_errors, n_compared, cyc, i;
  // version values are arbitrary
  encoder_status_alarm_regs #(.SPEED_CYC(100), .FW_MAJOR(16'h0A0B), .FW_MINOR(16'h0C0D),
    .BOARD_MAJOR(16'h0E0F), .BOARD_MINOR(16'h0102)) i_dut (.clk(clk), .arst_n(arst_n),
    .raw_position(raw_position), .preset_value(preset_value), .counts_per_rev(counts_per_rev),
    .total_resolution(total_resolution), .scaling_on(scaling_on), .count_ccw(count_ccw),
    .speed_rpm(speed_rpm), .cmd_preset(cmd_preset), .cmd_restore(cmd_restore),
    .cmd_save(cmd_save), .cpr_invalid(cpr_invalid), .total_invalid(total_invalid),
    .preset_invalid(preset_invalid), .flash_fault(flash_fault), .rd_req(rd_req),
    .rd_func(rd_func), .rd_addr(rd_addr), .rd_ack_r(rd_ack_r), .rd_err_r(rd_err_r),
    .rd_data_r(rd_data_r));
  modbus_client i_cli (.clk(clk), .rd_req(rd_req), .rd_func(rd_func), .rd_addr(rd_addr),
    .rd_ack_r(rd_ack_r), .rd_err_r(rd_err_r), .rd_data_r(rd_data_r));
  // ==========================================
  // helpers
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] f, input [15:0] a, input [31:0] exp);
    begin
      i_cli.rd_pair(f, a, v, e);
      chk({31'h0, e}, 32'h0);
      chk(v, exp);
    end
  endtask
  task pulse(input [2:0] m);
    begin
      @(posedge clk);
      {cmd_save, cmd_restore, cmd_preset} <= m;
      @(posedge clk);
      {cmd_save, cmd_restore, cmd_preset} <= 3'b000;
      repeat (2) @(posedge clk);
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ramp)
      raw_position <= raw_position + 32'h1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end
  initial begin
    {arst_n, scaling_on, count_ccw, speed_rpm, cmd_preset, cmd_restore, cmd_save} = 7'h00;
    {cpr_invalid, total_invalid, preset_invalid, flash_fault, ramp} = 5'h00;
    {raw_position, preset_value, n_errors, n_compared, cyc} = 0;
    counts_per_rev = 32'd1000;
    total_resolution = 32'h0010_0000;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rc(8'h04, 16'h0076, 32'h0);
    rc(8'h04, 16'h007A, 32'h0);
    rc(8'h04, 16'h0080, 32'h0A0B0C0D);
    rc(8'h04, 16'h0082, 32'h0E0F0102);
    rc(8'h04, 16'h007E, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      {count_ccw, scaling_on} <= i[1:0];
      rc(8'h04, 16'h0004, {30'h0, i[1:0]});
    end
    {count_ccw, scaling_on} <= 2'b00;
    for (i = 0; i < 3; i = i + 1) begin
      {preset_invalid, total_invalid, cpr_invalid} <= 3'b001 << i;
      rc(8'h04, 16'h0078, 32'h1000);
      rc(8'h04, 16'h007C, 32'h1 << i);
      rc(8'h04, 16'h0004, 32'h100);
    end
    cpr_invalid <= 1'b1;
    @(posedge clk);
    preset_invalid <= 1'b0;
    rc(8'h04, 16'h0078, 32'h1000);
    cpr_invalid <= 1'b0;
    rc(8'h04, 16'h0078, 32'h0);
    raw_position <= 32'h1234;
    preset_value <= 32'h100;
    pulse(3'b001);
    rc(8'h04, 16'h007E, 32'h1234);
    rc(8'h04, 16'h0000, 32'h100);
    raw_position <= 32'h1239;
    rc(8'h03, 16'h005E, 32'h105);
    raw_position <= 32'hFFFF_FF00;
    pulse(3'b001);
    pulse(3'b100);
    rc(8'h04, 16'h007C, 32'h8);
    raw_position <= 32'h10;
    pulse(3'b001);
    pulse(3'b100);
    rc(8'h04, 16'h007C, 32'h0);
    pulse(3'b010);
    rc(8'h04, 16'h007E, 32'h0);
    raw_position <= 32'h0001_2345;
    total_resolution <= 32'h0000_1000;
    scaling_on <= 1'b1;
    rc(8'h04, 16'h0000, 32'h445);
    scaling_on <= 1'b0;
    ramp <= 1'b1;
    repeat (250) @(posedge clk);
    rc(8'h04, 16'h0002, 32'd1000);
    speed_rpm <= 1'b1;
    repeat (250) @(posedge clk);
    rc(8'h03, 16'h0060, 32'd60);
    ramp <= 1'b0;
    i_cli.rd_word(8'h06, 16'h0000, w, e);
    chk({15'h0, e, w}, 32'h10000);
    i_cli.rd_word(8'h04, 16'h0010, w, e);
    chk({15'h0, e, w}, 32'h10000);
    flash_fault <= 1'b1;
    @(posedge clk);
    flash_fault <= 1'b0;
    pulse(3'b010);
    rc(8'h04, 16'h0078, 32'h4000);
    rc(8'h04, 16'h0004, 32'h100);
    wrap_up;
  end
endmodule
